// File: hdl/status_reporting_regs.vh
/*
   register map, field positions, reset values and timing counts of the status reporting block.
   assumes it is included by bare name from the design file.
*/
`ifndef STATUS_REPORTING_REGS_VH
`define STATUS_REPORTING_REGS_VH

// address layout: {select[3:0], bit mode, bit index[3:0]}
`define ADDR_SEL_MSB 8
`define ADDR_SEL_LSB 5
`define ADDR_BITMODE 4
`define ADDR_IDX_MSB 3

// register selects
`define SEL_STATUS_BYTE 4'h0
`define SEL_SRQ_ENABLE 4'h1
`define SEL_EVENT_FLAGS 4'h2
`define SEL_EVENT_ENABLE 4'h3
`define SEL_COMM_FLAGS 4'h4
`define SEL_COMM_ENABLE 4'h5
`define SEL_INST_LIVE 4'h6
`define SEL_INST_FLAGS 4'h7
`define SEL_INST_ENABLE 4'h8
`define SEL_ADC_FLAGS 4'h9
`define SEL_ADC_ENABLE 4'ha
`define SEL_CONTROL 4'hb
`define SEL_IRQ_STATUS 4'hc
`define SEL_IRQ_MASK 4'hd

// status byte bit positions
`define STB_INST_SUM 0
`define STB_ADC_SUM 1
`define STB_COMM_SUM 2
`define STB_EVENT_SUM 5
`define STB_MASTER 6

// standard event flags
`define EVT_EXEC_ERROR 4

// control register
`define CTRL_PULSE_MODE 0
`define CTRL_CLEAR_STATUS 1

// interrupt status bits
`define IRQ_NEW_SRQ 0
`define IRQ_EXEC_ERROR 1
`define IRQ_COMM_ERROR 2
`define IRQ_ADC_READY 3

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_IRQ 4'h0
`define RST_PULSE_MODE 1'b0

// timing
`define CLK_PERIOD_NS 5
`define SRQ_PULSE_MIN_NS 1000
`define SRQ_PULSE_CYCLES ((`SRQ_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: hdl/status_reporting_registers.v
/*
   status reporting register set: status byte, service request enable, standard event flags,
   comm error flags, instrument condition/event flags, converter data-ready flags, each with
   an enable mask, plus the active-low service request line and a maskable interrupt.
   assumes a single clock, synchronous inputs, and a register port master that never issues
   read and write strobes together.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "status_reporting_regs.vh"

// Overview of operation
// - full status byte read releases the service request line in latched mode, not in pulse mode
// - single-bit status byte read leaves the service request line alone
// - status byte read returns whole byte or only the addressed bit
// - service request mask written and read whole or per bit; bit 5 weighs 32
// - event flag read clears exactly the bits it returned
// - illegal parameter sets execution error flag, value 16
// - event enable mask written and read whole or per bit
// - comm error flag read clears exactly the bits it returned
// - comm error enable mask written and read whole or per bit
// - instrument condition shows live state of the instrument condition inputs
// - reading instrument condition changes nothing
// - instrument event flags readable whole or per bit
// - instrument event enable mask written and read whole or per bit
// - new converter result sets the data-ready bit of its channel
// - data-ready enable mask written and read whole or per bit
// - pulse mode gives at least 1 us low pulse, else latched; off at reset
// - clear status zeroes event, comm error, instrument and converter data-ready flag registers
module status_reporting_registers #(
   parameter BYTE_W = 8,
   parameter ADC_W = 16
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   input wire ce,
   // register port
   input wire [8:0] regAddr,
   input wire [15:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [15:0] regRdata,
   // instrument events
   input wire [BYTE_W-1:0] eventSources,
   input wire execErrorEvent,
   input wire [BYTE_W-1:0] commErrorEvents,
   input wire [BYTE_W-1:0] instrumentCondition,
   input wire adcResultValid,
   input wire [3:0] adcChannel,
   // host side outputs
   output reg serviceRequestN,
   output reg irq
);

   localparam [1:0] SRQ_IDLE = 2'h0;
   localparam [1:0] SRQ_HELD = 2'h1;
   localparam [1:0] SRQ_PULSE = 2'h2;
   localparam integer PULSE_LAST_INT = `SRQ_PULSE_CYCLES - 1;
   localparam [7:0] PULSE_LAST = PULSE_LAST_INT[7:0];

   wire [3:0] sel = regAddr[`ADDR_SEL_MSB:`ADDR_SEL_LSB];
   wire bitMode = regAddr[`ADDR_BITMODE];
   wire [3:0] idx = regAddr[`ADDR_IDX_MSB:0];
   wire [15:0] bitSel = 16'h0001 << idx;
   wire [15:0] readMask = bitMode ? bitSel : 16'hffff;
   wire [15:0] adcBit = 16'h0001 << adcChannel;

   reg [BYTE_W-1:0] srqEnable_reg;
   reg [BYTE_W-1:0] eventFlags_reg;
   reg [BYTE_W-1:0] eventEnable_reg;
   reg [BYTE_W-1:0] commFlags_reg;
   reg [BYTE_W-1:0] commEnable_reg;
   reg [BYTE_W-1:0] instFlags_reg;
   reg [BYTE_W-1:0] instEnable_reg;
   reg [BYTE_W-1:0] instPrev_reg;
   reg [ADC_W-1:0] adcFlags_reg;
   reg [ADC_W-1:0] adcEnable_reg;
   reg pulseMode_reg;
   reg [3:0] irqStatus_reg;
   reg [3:0] irqMask_reg;
   reg [1:0] srqState_reg;
   reg [1:0] srqState_next;
   reg [7:0] pulseCount_reg;
   reg [7:0] pulseCount_next;
   reg srqCondPrev_reg;

   // whole-or-bit write of a mask register
   function [15:0] maskWrite;
      input [15:0] old;
      input [15:0] data;
      input bm;
      input [15:0] bs;
      begin
         if (bm) begin
            maskWrite = data[0] ? (old | bs) : (old & ~bs);
         end else begin
            maskWrite = data;
         end
      end
   endfunction

   wire wrSel = regWr;
   wire wrSre = wrSel && (sel == `SEL_SRQ_ENABLE);
   wire wrEse = wrSel && (sel == `SEL_EVENT_ENABLE);
   wire wrCese = wrSel && (sel == `SEL_COMM_ENABLE);
   wire wrInse = wrSel && (sel == `SEL_INST_ENABLE);
   wire wrAdse = wrSel && (sel == `SEL_ADC_ENABLE);
   wire wrCtrl = wrSel && (sel == `SEL_CONTROL);
   wire wrIrqMask = wrSel && (sel == `SEL_IRQ_MASK);
   wire wrIrqClr = wrSel && (sel == `SEL_IRQ_STATUS);
   wire clearStatus = wrCtrl && regWdata[`CTRL_CLEAR_STATUS];
   wire [15:0] sreNew = maskWrite({{(16-BYTE_W){1'b0}}, srqEnable_reg}, regWdata, bitMode, bitSel);
   wire [15:0] eseNew = maskWrite({{(16-BYTE_W){1'b0}}, eventEnable_reg}, regWdata, bitMode,
      bitSel);
   wire [15:0] ceseNew = maskWrite({{(16-BYTE_W){1'b0}}, commEnable_reg}, regWdata, bitMode,
      bitSel);
   wire [15:0] inseNew = maskWrite({{(16-BYTE_W){1'b0}}, instEnable_reg}, regWdata, bitMode,
      bitSel);
   wire [15:0] adseNew = maskWrite({{(16-ADC_W){1'b0}}, adcEnable_reg}, regWdata, bitMode,
      bitSel);

   // status byte summary and request condition
   wire instSum = |(instFlags_reg & instEnable_reg);
   wire adcSum = |(adcFlags_reg & adcEnable_reg);
   wire commSum = |(commFlags_reg & commEnable_reg);
   wire eventSum = |(eventFlags_reg & eventEnable_reg);
   reg [BYTE_W-1:0] stbLow;
   always @* begin
      stbLow = {BYTE_W{1'b0}};
      stbLow[`STB_INST_SUM] = instSum;
      stbLow[`STB_ADC_SUM] = adcSum;
      stbLow[`STB_COMM_SUM] = commSum;
      stbLow[`STB_EVENT_SUM] = eventSum;
   end
   wire srqCond = |(stbLow & srqEnable_reg);
   wire [BYTE_W-1:0] statusByte = stbLow | ({{(BYTE_W-1){1'b0}}, srqCond} << `STB_MASTER);
   wire newRequest = srqCond && !srqCondPrev_reg;
   wire fullStbRead = regRd && !bitMode && (sel == `SEL_STATUS_BYTE);

   // flag set and read-clear terms
   wire [BYTE_W-1:0] execBit = {{(BYTE_W-1){1'b0}}, execErrorEvent} << `EVT_EXEC_ERROR;
   wire [BYTE_W-1:0] eventSet = eventSources | execBit;
   wire [BYTE_W-1:0] eventClr = (regRd && sel == `SEL_EVENT_FLAGS) ?
      readMask[BYTE_W-1:0] : {BYTE_W{1'b0}};
   wire [BYTE_W-1:0] commClr = (regRd && sel == `SEL_COMM_FLAGS) ?
      readMask[BYTE_W-1:0] : {BYTE_W{1'b0}};
   wire [ADC_W-1:0] adcSet = adcResultValid ? adcBit[ADC_W-1:0] : {ADC_W{1'b0}};
   wire [BYTE_W-1:0] instRise;

   // per-bit latching of instrument condition rising edges
   genvar g;
   generate
      for (g = 0; g < BYTE_W; g = g + 1) begin : instLatch
         assign instRise[g] = instrumentCondition[g] & ~instPrev_reg[g];
      end
   endgenerate

   // read data mux
   reg [15:0] readWord;
   always @* begin
      readWord = 16'h0000;
      case (sel)
         `SEL_STATUS_BYTE: readWord[BYTE_W-1:0] = statusByte;
         `SEL_SRQ_ENABLE: readWord[BYTE_W-1:0] = srqEnable_reg;
         `SEL_EVENT_FLAGS: readWord[BYTE_W-1:0] = eventFlags_reg;
         `SEL_EVENT_ENABLE: readWord[BYTE_W-1:0] = eventEnable_reg;
         `SEL_COMM_FLAGS: readWord[BYTE_W-1:0] = commFlags_reg;
         `SEL_COMM_ENABLE: readWord[BYTE_W-1:0] = commEnable_reg;
         `SEL_INST_LIVE: readWord[BYTE_W-1:0] = instrumentCondition;
         `SEL_INST_FLAGS: readWord[BYTE_W-1:0] = instFlags_reg;
         `SEL_INST_ENABLE: readWord[BYTE_W-1:0] = instEnable_reg;
         `SEL_ADC_FLAGS: readWord[ADC_W-1:0] = adcFlags_reg;
         `SEL_ADC_ENABLE: readWord[ADC_W-1:0] = adcEnable_reg;
         `SEL_CONTROL: readWord[`CTRL_PULSE_MODE] = pulseMode_reg;
         `SEL_IRQ_STATUS: readWord[3:0] = irqStatus_reg;
         `SEL_IRQ_MASK: readWord[3:0] = irqMask_reg;
         default: readWord = 16'h0000;
      endcase
   end
   wire readBit = |(readWord & bitSel);
   wire [15:0] readValue = bitMode ? {15'h0000, readBit} : readWord;

   // service request line state machine
   always @* begin
      srqState_next = srqState_reg;
      pulseCount_next = pulseCount_reg;
      case (srqState_reg)
         SRQ_IDLE: begin
            if (newRequest && pulseMode_reg) begin
               srqState_next = SRQ_PULSE;
               pulseCount_next = PULSE_LAST;
            end else if (newRequest) begin
               srqState_next = SRQ_HELD;
            end
         end
         SRQ_HELD: begin
            if (fullStbRead) begin
               srqState_next = SRQ_IDLE;
            end
         end
         SRQ_PULSE: begin
            if (pulseCount_reg == 8'h00) begin
               srqState_next = SRQ_IDLE;
            end else begin
               pulseCount_next = pulseCount_reg - 8'h01;
            end
         end
         default: srqState_next = SRQ_IDLE;
      endcase
   end

   wire [3:0] irqSet = {adcResultValid, |commErrorEvents, execErrorEvent, newRequest};
   wire [3:0] irqClr = wrIrqClr ? regWdata[3:0] : 4'h0;
   wire [3:0] irqStatusNext = (irqStatus_reg & ~irqClr) | irqSet;

   always @(posedge clk) begin
      if (sys_rst) begin
         srqEnable_reg <= `RST_BYTE;
         eventFlags_reg <= `RST_BYTE;
         eventEnable_reg <= `RST_BYTE;
         commFlags_reg <= `RST_BYTE;
         commEnable_reg <= `RST_BYTE;
         instFlags_reg <= `RST_BYTE;
         instEnable_reg <= `RST_BYTE;
         instPrev_reg <= `RST_BYTE;
         adcFlags_reg <= `RST_WORD;
         adcEnable_reg <= `RST_WORD;
         pulseMode_reg <= `RST_PULSE_MODE;
         irqStatus_reg <= `RST_IRQ;
         irqMask_reg <= `RST_IRQ;
         srqState_reg <= SRQ_IDLE;
         pulseCount_reg <= 8'h00;
         srqCondPrev_reg <= 1'b0;
         regRdata <= 16'h0000;
         serviceRequestN <= 1'b1;
         irq <= 1'b0;
      end else if (ce) begin
         if (wrSre) srqEnable_reg <= sreNew[BYTE_W-1:0];
         if (wrEse) eventEnable_reg <= eseNew[BYTE_W-1:0];
         if (wrCese) commEnable_reg <= ceseNew[BYTE_W-1:0];
         if (wrInse) instEnable_reg <= inseNew[BYTE_W-1:0];
         if (wrAdse) adcEnable_reg <= adseNew[ADC_W-1:0];
         if (wrCtrl) pulseMode_reg <= regWdata[`CTRL_PULSE_MODE];
         if (wrIrqMask) irqMask_reg <= regWdata[3:0];
         // new events win over read clears; clear status wipes all flag sets
         if (clearStatus) begin
            eventFlags_reg <= `RST_BYTE;
            commFlags_reg <= `RST_BYTE;
            instFlags_reg <= `RST_BYTE;
            adcFlags_reg <= `RST_WORD;
         end else begin
            eventFlags_reg <= (eventFlags_reg & ~eventClr) | eventSet;
            commFlags_reg <= (commFlags_reg & ~commClr) | commErrorEvents;
            instFlags_reg <= instFlags_reg | instRise;
            adcFlags_reg <= adcFlags_reg | adcSet;
         end
         instPrev_reg <= instrumentCondition;
         irqStatus_reg <= irqStatusNext;
         irq <= |(irqStatusNext & irqMask_reg);
         srqState_reg <= srqState_next;
         pulseCount_reg <= pulseCount_next;
         srqCondPrev_reg <= srqCond;
         serviceRequestN <= (srqState_next == SRQ_IDLE);
         regRdata <= regRd ? readValue : 16'h0000;
      end
   end

endmodule // status_reporting_registers

// File: testbench/status_reporting_assertions.sv
/* checker for the status reporting block, bound to its top.
   assumes ce is held high. */
module status_reporting_assertions #(parameter BYTE_W = 8) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // register port
   input wire [8:0] regAddr,
   input wire [15:0] regWdata,
   input wire regWr,
   input wire regRd,
   input wire [15:0] regRdata,
   // events and request line
   input wire [BYTE_W-1:0] eventSources,
   input wire execErrorEvent,
   input wire [BYTE_W-1:0] commErrorEvents,
   input wire [BYTE_W-1:0] instrumentCondition,
   input wire serviceRequestN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pm = 1'b0;
   logic [8:0] lowCnt = 9'h0;
   // pulse mode shadow and low stretch count
   always @(posedge clk) begin
      if (sys_rst) pm <= 1'b0;
      else if (regWr && regAddr[8:5] == 4'hb && (!regAddr[4] || regAddr[3:0] == 4'h0))
         pm <= regWdata[0];
      lowCnt <= serviceRequestN ? 9'h0 : lowCnt + {8'h0, lowCnt != 9'h1ff};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_rdata_idle:
      assert property (!$past(regRd) |-> regRdata == 16'h0) else $error("read data not idle");
   a_bit_width:
      assert property ($past(regRd) && ($past(regAddr) & 9'h10) != 9'h0
         |-> regRdata[15:1] == 15'h0) else $error("bit read too wide");
   a_full_release:
      assert property (!pm && regRd && regAddr[8:4] == 5'h0 |=> serviceRequestN)
         else $error("request not released");
   a_bit_keep:
      assert property (!pm && !serviceRequestN && regRd && regAddr[8:4] == 5'h1
         |=> !serviceRequestN) else $error("bit read released request");
   a_event_clear:
      assert property (regRd && regAddr == 9'h40 && eventSources == 0 && !execErrorEvent
         ##1 regRd && regAddr == 9'h40 |=> regRdata == 16'h0) else $error("event not cleared");
   a_comm_clear:
      assert property (regRd && regAddr == 9'h80 && commErrorEvents == 0
         ##1 regRd && regAddr == 9'h80 |=> regRdata == 16'h0) else $error("comm not cleared");
   a_live_view:
      assert property (regRd && regAddr == 9'hc0 && $stable(instrumentCondition)
         |=> regRdata == {8'h0, $past(instrumentCondition)}) else $error("live view wrong");
   a_enable_back:
      assert property (regWr && regAddr[4] && regAddr[8:5] inside {4'h1, 4'h3, 4'h5, 4'h8, 4'ha}
         ##1 regRd && $stable(regAddr) |=> regRdata == ($past(regWdata, 2) & 16'h1))
         else $error("enable bit readback wrong");
   a_pulse_min:
      assert property (pm && $rose(serviceRequestN) |-> lowCnt >= 9'd200)
         else $error("request pulse too short");
   c_pulse: cover property (pm && $rose(serviceRequestN));
   c_release: cover property (regRd && regAddr == 9'h0 && !serviceRequestN);
   c_clear: cover property (regRd && regAddr == 9'h40 ##1 regRd && regAddr == 9'h40);
endmodule // status_reporting_assertions

bind status_reporting_registers status_reporting_assertions #(.BYTE_W(BYTE_W)) u_chk (
   .clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .eventSources,
   .execErrorEvent, .commErrorEvents, .instrumentCondition, .serviceRequestN);

// File: testbench/srq_host_model.sv
/* host model: measures each low stretch of the request line.
   assumes the line is sampled on the block clock. */
module srq_host_model (
   // clock
   input wire clk,
   // request line and measured stretch
   input wire serviceRequestN,
   output logic [8:0] lowLen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] run = 9'h0;
   initial lowLen = 9'h0;
   always @(posedge clk) begin
      if (!serviceRequestN) run <= run + 9'h1;
      else if (run != 9'h0) begin
         lowLen <= run;
         run <= 9'h0;
      end
   end
endmodule // srq_host_model

// File: testbench/status_reporting_registers_tb_top.sv
/* directed bench for the status reporting registers.
   assumes checker and host model are compiled first. */
module status_reporting_registers_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic [8:0] regAddr = 9'h0;
   logic [15:0] regWdata = 16'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] eventSources = 8'h0;
   logic execErrorEvent = 1'b0;
   logic [7:0] commErrorEvents = 8'h0;
   logic [7:0] instrumentCondition = 8'h0;
   logic adcResultValid = 1'b0;
   logic [3:0] adcChannel = 4'h0;
   logic [3:0] enSel [5] = '{4'h1, 4'h3, 4'h5, 4'h8, 4'ha};
   wire [15:0] regRdata;
   wire serviceRequestN;
   wire irq;
   wire [8:0] lowLen;
   int errorCnt = 0;
   int totalChecks = 0;
   initial forever #2.5 clk = ~clk;
   status_reporting_registers u_status_reporting_registers (.clk, .sys_rst(sysRst), .ce(1'b1),
      .regAddr, .regWdata, .regWr, .regRd, .regRdata, .eventSources, .execErrorEvent,
      .commErrorEvents, .instrumentCondition, .adcResultValid, .adcChannel, .serviceRequestN, .irq);
   srq_host_model u_srq_host_model (.clk, .serviceRequestN, .lowLen);
   task automatic closeOut;
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 cmp(regRdata, e);
   endtask
   task automatic kick(input logic [7:0] s, input logic x, input logic [7:0] c);
      eventSources <= s;
      execErrorEvent <= x;
      commErrorEvents <= c;
      @(posedge clk);
      eventSources <= 8'h0;
      execErrorEvent <= 1'b0;
      commErrorEvents <= 8'h0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      foreach (enSel[k]) begin
         wr({enSel[k], 5'h12}, 16'h1);
         rd({enSel[k], 5'h12}, 16'h1);
         rd({enSel[k], 5'h00}, 16'h4);
      end
      wr(9'h020, 16'h20);
      rd(9'h035, 16'h1);
      rd(9'h020, 16'h20);
      kick(8'h0, 1'b0, 8'h06);
      rd(9'h091, 16'h1);
      rd(9'h080, 16'h4);
      rd(9'h080, 16'h0);
      kick(8'h09, 1'b1, 8'h0);
      rd(9'h050, 16'h1);
      rd(9'h040, 16'h18);
      rd(9'h040, 16'h0);
      instrumentCondition <= 8'h12;
      idle(3);
      rd(9'h0c0, 16'h12);
      rd(9'h0c0, 16'h12);
      rd(9'h0e0, 16'h12);
      rd(9'h0f4, 16'h1);
      instrumentCondition <= 8'h02;
      idle(3);
      rd(9'h0c0, 16'h2);
      adcResultValid <= 1'b1;
      adcChannel <= 4'h3;
      @(posedge clk);
      adcChannel <= 4'hf;
      @(posedge clk);
      adcResultValid <= 1'b0;
      rd(9'h120, 16'h8008);
      wr(9'h060, 16'h10);
      kick(8'h0, 1'b1, 8'h0);
      idle(4);
      cmp(serviceRequestN, 1'b0);
      rd(9'h015, 16'h1);
      idle(2);
      cmp(serviceRequestN, 1'b0);
      rd(9'h000, 16'h60);
      idle(2);
      cmp(serviceRequestN, 1'b1);
      wr(9'h160, 16'h2);
      rd(9'h040, 16'h0);
      rd(9'h0e0, 16'h0);
      rd(9'h120, 16'h0);
      wr(9'h160, 16'h1);
      kick(8'h0, 1'b1, 8'h0);
      idle(3);
      rd(9'h000, 16'h60);
      idle(250);
      cmp(lowLen, 16'd200);
      wr(9'h160, 16'h0);
      wr(9'h180, 16'hf);
      wr(9'h1a0, 16'h2);
      idle(2);
      cmp(irq, 1'b0);
      kick(8'h0, 1'b1, 8'h01);
      idle(2);
      cmp(irq, 1'b1);
      wr(9'h180, 16'h2);
      idle(2);
      cmp(irq, 1'b0);
      rd(9'h180, 16'h4);
      wr(9'h1c0, 16'hffff);
      rd(9'h1c0, 16'h0);
      closeOut;
   end
   initial begin
      repeat (3000) @(posedge clk);
      errorCnt++;
      closeOut;
   end
endmodule // status_reporting_registers_tb_top
